/* File: design/interval_timer_consts.svh */
// Constants for the 16-bit interval timer.
// Assumes inclusion by bare name from design files.
//
// Contract
// R1: Before event count mode, software clears both capture edge select bits to 00.
// R2: For trigger pulse, one-shot and pulse width modes, software clears the event clock select bit.
// R3: With mode 000 and run set, the period match interrupt repeats at the programmed interval.
// R4: The toggle output gives a square wave whose half period equals one interval.
// R5: On run, the counter steps FFFFH to 0000H on the next count clock and the toggle output inverts.
// R6: At start of counting the period register is copied into the shadow compare register.
// R7: On counter equal to shadow, the counter clears, the output inverts and the interrupt pulses.
// R8: Interrupt spacing is the period value plus one count clocks.
// R9: With period 0000H the counter stays at 0000H and matches on every count after the first.
// R10: With period FFFFH the counter clears after FFFFH without wrap interrupt or wrap flag.
// R11: Software should stop counting before lowering the period value.
// R12: A period write while counting reaches the shadow at once and is compared at once.
// R13: A smaller period below the count makes the counter wrap through zero before matching.
// R14: The second compare register takes no part in interval mode.
// R15: The current counter value is readable on a readback port.
// R16: While run is 0 the counter is held at FFFFH.
`ifndef INTERVAL_TIMER_CONSTS_SVH
`define INTERVAL_TIMER_CONSTS_SVH
`define CNT_W 16
`define CNT_IDLE 16'hffff
`define CNT_ZERO 16'h0000
`define CMP_RESET 16'hffff
`define MODE_W 3
`define MODE_INTERVAL 3'h0
`define SYNC_STAGES 2
`endif

/* File: design/interval_timer_pkg.sv */
// Types for the 16-bit interval timer.
// Assumes the constants header is compiled alongside.
package interval_timer_pkg;
    typedef logic [15:0] count_t;
    typedef enum logic [0:0] {st_idle, st_run} run_state_e;
endpackage

/* File: design/count_edge_sync.sv */
// Synchroniser and rising-edge detector for the count clock input.
// Assumes the count clock is far slower than the system clock.
`timescale 1ns/1ps
`default_nettype none
module count_edge_sync (
    input wire logic clock,
    input wire logic rst,
    input wire logic async_in,
    output logic rise
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // First stage is read only by the second stage
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign rise = sync_q & ~last_q;
endmodule
`default_nettype wire

/* File: design/shadow_compare.sv */
// Shadow compare register for the period value.
// Loads at run start and on any period write while running.
`timescale 1ns/1ps
`default_nettype none
`include "interval_timer_consts.svh"
module shadow_compare (
    input wire logic clock,
    input wire logic rst,
    input wire logic load,
    input wire logic [15:0] load_value,
    output logic [15:0] shadow
);
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            shadow <= `CMP_RESET;
        end else if (load) begin
            shadow <= load_value;
        end
    end
endmodule
`default_nettype wire

/* File: design/interval_timer.sv */
// Interval timer mode of one 16-bit timer unit.
// Assumes control bits and the internal count clock tick come from same-clock logic; only the event pin is synchronised.
`timescale 1ns/1ps
`default_nettype none
`include "interval_timer_consts.svh"
module interval_timer (
    input wire logic clock,
    input wire logic rst,
    input wire logic run_control_bit,
    input wire logic [2:0] op_mode_field,
    input wire logic event_clock_select,
    input wire logic internal_tick,
    input wire logic event_count_pin,
    input wire logic [15:0] period_compare_reg,
    input wire logic period_write,
    input wire logic [15:0] second_compare_reg,
    input wire logic toggle_output_enable,
    input wire logic toggle_output_level,
    output logic toggle_output_pin,
    output logic period_match_irq,
    output logic wrap_irq,
    output logic wrap_flag,
    output logic [15:0] count_readback_reg,
    output logic [15:0] period_compare_shadow
);

    ////////////////////////////////////////////////////////////////////////
    // Count clock selection

    logic event_rise;
    logic count_tick;
    logic active;

    count_edge_sync u_sync (
        .clock(clock),
        .rst(rst),
        .async_in(event_count_pin),
        .rise(event_rise)
    );

    assign active = run_control_bit && (op_mode_field == `MODE_INTERVAL);
    assign count_tick = event_clock_select ? event_rise : internal_tick;

    ////////////////////////////////////////////////////////////////////////
    // Run state and shadow loading

    interval_timer_pkg::run_state_e state_q;
    logic start;
    logic shadow_load;

    assign start = active && (state_q == interval_timer_pkg::st_idle);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= interval_timer_pkg::st_idle;
        end else begin
            case (state_q)
                interval_timer_pkg::st_idle: begin
                    if (active) begin
                        state_q <= interval_timer_pkg::st_run;
                    end
                end
                default: begin
                    if (!active) begin
                        state_q <= interval_timer_pkg::st_idle;
                    end
                end
            endcase
        end
    end

    // R6 R12: load at start, and at once on writes while running
    assign shadow_load = start || (active && period_write);

    shadow_compare u_shadow (
        .clock(clock),
        .rst(rst),
        .load(shadow_load),
        .load_value(period_compare_reg),
        .shadow(period_compare_shadow)
    );

    ////////////////////////////////////////////////////////////////////////
    // Counter

    interval_timer_pkg::count_t count_q;
    logic match;
    logic first_q;
    logic run_tick;

    // R7 R12: compare against shadow, or the fresh value on a write cycle
    assign match = count_q == (period_write ? period_compare_reg : period_compare_shadow);

    // R5 R16: FFFFH while stopped, first tick steps to 0000H
    // R13 R10: past-compare values free-run and wrap through zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_q <= `CNT_IDLE;
        end else if (!active) begin
            count_q <= `CNT_IDLE;
        end else if (count_tick) begin
            if (state_q == interval_timer_pkg::st_idle || first_q) begin
                count_q <= `CNT_ZERO;
            end else if (match) begin
                count_q <= `CNT_ZERO;
            end else begin
                count_q <= count_q + 16'h0001;
            end
        end
    end

    // First tick after run still leaves the FFFFH idle value
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            first_q <= 1'b0;
        end else if (!active) begin
            first_q <= 1'b0;
        end else if (start) begin
            first_q <= !count_tick;
        end else if (count_tick) begin
            first_q <= 1'b0;
        end
    end

    logic first_step;
    logic period_event;
    // Ticks while stopped must not reach the events, the shadow may still hold FFFFH then
    assign run_tick = active && count_tick && !start && !first_q;
    assign first_step = count_tick && (start || first_q);
    // R3 R8 R9: match on a tick after the first step
    assign period_event = run_tick && match;

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // R7: one-cycle interrupt pulse on match
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            period_match_irq <= 1'b0;
        end else begin
            period_match_irq <= period_event;
        end
    end

    // R4 R5: toggle on the first step and on each match
    logic toggle_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            toggle_q <= 1'b0;
        end else if (!active) begin
            toggle_q <= 1'b0;
        end else if (first_step || period_event) begin
            toggle_q <= ~toggle_q;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            toggle_output_pin <= 1'b0;
        end else begin
            if (toggle_output_enable) begin
                toggle_output_pin <= toggle_q ^ toggle_output_level;
            end else begin
                toggle_output_pin <= toggle_output_level;
            end
        end
    end

    // R10 R13: wrap only when counting through FFFFH without a match there
    logic wrap_event;
    assign wrap_event = run_tick && !match && (count_q == `CNT_IDLE);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wrap_irq <= 1'b0;
        end else begin
            wrap_irq <= wrap_event;
        end
    end

    // Sticky until the next run start, since there is no register write path here
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wrap_flag <= 1'b0;
        end else if (wrap_event) begin
            wrap_flag <= 1'b1;
        end else if (start) begin
            wrap_flag <= 1'b0;
        end
    end

    // R15: counter readback from a register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_readback_reg <= `CNT_IDLE;
        end else begin
            count_readback_reg <= count_q;
        end
    end

    // R14: the second compare input is unused in this mode
    logic unused_second;
    assign unused_second = ^second_compare_reg;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    // Helper for R8 R13: run ticks since the last match and the parity of wraps in between
    logic [16:0] gap_q;
    logic wrap_odd_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            gap_q <= 17'h00000;
        end else if (first_step || period_event) begin
            gap_q <= 17'h00000;
        end else if (run_tick) begin
            gap_q <= gap_q + 17'h00001;
        end
    end

    // Parity rather than a flag, so a second wrap folds back the way the 17-bit gap does
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wrap_odd_q <= 1'b0;
        end else if (first_step || period_event) begin
            wrap_odd_q <= 1'b0;
        end else if (wrap_event) begin
            wrap_odd_q <= ~wrap_odd_q;
        end
    end

    sequence run_tick_s;
        active && count_tick && !start && !first_q;
    endsequence

    sequence cleared_s;
        count_q == `CNT_ZERO ##0 period_match_irq;
    endsequence

    // R16 held while stopped
    idle_hold_a: assert property (@(posedge clock) disable iff (rst) // R16
        !active |=> count_q == `CNT_IDLE) else $error("counter not held while stopped");
    // R16 quiet while stopped
    stop_quiet_a: assert property (@(posedge clock) disable iff (rst) // R16
        !active |=> !period_match_irq && !wrap_irq) else $error("event while stopped");
    // R5 first step
    first_step_a: assert property (@(posedge clock) disable iff (rst) // R5
        active && first_step |=> count_q == `CNT_ZERO) else $error("first step not to zero");
    // R5 toggle at start
    first_toggle_a: assert property (@(posedge clock) disable iff (rst) // R5
        active && first_step |=> toggle_q != $past(toggle_q)) else $error("no toggle at start");
    // R3 run state
    run_state_a: assert property (@(posedge clock) disable iff (rst) // R3
        active |=> state_q == interval_timer_pkg::st_run) else $error("run state not entered");
    // R3 count up
    count_step_a: assert property (@(posedge clock) disable iff (rst) // R3
        run_tick_s and !match |=> count_q == $past(count_q) + 16'h0001) else $error("count did not step");
    // R3 hold between ticks
    tick_hold_a: assert property (@(posedge clock) disable iff (rst) // R3
        active && !count_tick |=> $stable(count_q)) else $error("count moved without tick");
    // R7 clear on match
    match_clear_a: assert property (@(posedge clock) disable iff (rst) // R7
        run_tick_s and match |=> cleared_s) else $error("match did not clear");
    // R7 interrupt cause
    irq_cause_a: assert property (@(posedge clock) disable iff (rst) // R7
        period_match_irq |-> $past(match) && $past(count_tick)) else $error("spurious interrupt");
    // R7 toggle on match
    toggle_match_a: assert property (@(posedge clock) disable iff (rst) // R7
        period_event |=> toggle_q != $past(toggle_q)) else $error("no toggle on match");
    // R4 toggle holds otherwise
    toggle_hold_a: assert property (@(posedge clock) disable iff (rst) // R4
        active && !first_step && !period_event |=> $stable(toggle_q)) else $error("toggle moved");
    // R4 pin driven
    pin_drive_a: assert property (@(posedge clock) disable iff (rst) // R4
        toggle_output_enable |=> toggle_output_pin == ($past(toggle_q) ^ $past(toggle_output_level)))
        else $error("pin not following toggle");
    // R4 pin idle
    pin_idle_a: assert property (@(posedge clock) disable iff (rst) // R4
        !toggle_output_enable |=> toggle_output_pin == $past(toggle_output_level)) else $error("pin not idle");
    // R6 shadow at start
    shadow_start_a: assert property (@(posedge clock) disable iff (rst) // R6
        start |=> period_compare_shadow == $past(period_compare_reg)) else $error("shadow not loaded");
    // R12 shadow on write
    shadow_write_a: assert property (@(posedge clock) disable iff (rst) // R12
        active && period_write |=> period_compare_shadow == $past(period_compare_reg)) else $error("write lost");
    // R12 shadow holds otherwise
    shadow_hold_a: assert property (@(posedge clock) disable iff (rst) // R12
        !shadow_load |=> $stable(period_compare_shadow)) else $error("shadow changed");
    // R8 R13 interval length
    interval_len_a: assert property (@(posedge clock) disable iff (rst) // R8
        run_tick_s and match and !period_write |-> gap_q == {wrap_odd_q, period_compare_shadow})
        else $error("interval length wrong");
    // R9 zero period
    zero_period_a: assert property (@(posedge clock) disable iff (rst) // R9
        run_tick_s and count_q == `CNT_ZERO and period_compare_shadow == `CNT_ZERO and !period_write |=> cleared_s)
        else $error("zero period not matching");
    // R10 no wrap on match
    no_wrap_a: assert property (@(posedge clock) disable iff (rst) // R10
        run_tick_s and match |=> !wrap_irq) else $error("wrap on match");
    // R10 full period
    full_period_a: assert property (@(posedge clock) disable iff (rst) // R10
        run_tick_s and count_q == `CNT_IDLE and period_compare_shadow == `CNT_IDLE and !period_write
        |=> cleared_s ##0 !wrap_irq) else $error("full period mishandled");
    // R13 wrap through zero
    wrap_step_a: assert property (@(posedge clock) disable iff (rst) // R13
        run_tick_s and !match and count_q == `CNT_IDLE |=> count_q == `CNT_ZERO && wrap_irq)
        else $error("wrap not through zero");
    // R13 flag on wrap
    flag_set_a: assert property (@(posedge clock) disable iff (rst) // R13
        wrap_irq |-> wrap_flag) else $error("wrap flag not set");
    // R13 flag sticky
    flag_sticky_a: assert property (@(posedge clock) disable iff (rst) // R13
        wrap_flag && !start |=> wrap_flag) else $error("wrap flag lost");
    // R15 readback copy
    readback_a: assert property (@(posedge clock) disable iff (rst) // R15
        1'b1 |=> count_readback_reg == $past(count_q)) else $error("readback stale");

endmodule
`default_nettype wire

/* File: test/interval_timer_tb.sv */
// Self-checking bench for the interval timer, driving its ports directly.
// Assumes the design files and the constants header are compiled first.
`timescale 1ns/1ps
`default_nettype none
module interval_timer_tb;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic run = 1'b0;
    logic [2:0] mode = 3'h0;
    logic ecs = 1'b0;
    logic tick = 1'b0;
    logic epin = 1'b0;
    logic [15:0] per = 16'h0002;
    logic pw = 1'b0;
    logic [15:0] cmp2 = 16'h0000;
    logic lvl = 1'b0;
    logic oe = 1'b1;
    logic pin, irq, wirq, wflag, pin_p;
    logic [15:0] rb, shd;
    int mismatches = 0;
    int n_checks = 0;
    int ticks_n, last_m, irqs, wraps, togs, ivl;

    interval_timer i_dut (.clock(clock), .rst(rst), .run_control_bit(run), .op_mode_field(mode),
        .event_clock_select(ecs), .internal_tick(tick), .event_count_pin(epin), .period_compare_reg(per),
        .period_write(pw), .second_compare_reg(cmp2), .toggle_output_enable(oe),
        .toggle_output_level(lvl), .toggle_output_pin(pin), .period_match_irq(irq), .wrap_irq(wirq),
        .wrap_flag(wflag), .count_readback_reg(rb), .period_compare_shadow(shd));

    always #10 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////////////
    // Monitor reads pre-edge values, so an interrupt seen here belongs to the tick one edge back
    always @(posedge clock) begin
        if (irq === 1'b1) begin
            ivl = ticks_n - last_m;
            last_m = ticks_n;
            irqs++;
        end
        if (wirq === 1'b1) wraps++;
        if (pin !== pin_p) togs++;
        pin_p = pin;
        if (tick) ticks_n++;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    // One count clock per system clock, then let the registered outputs settle
    task automatic ticks(input int n);
        tick = 1'b1;
        cyc(n);
        tick = 1'b0;
        cyc(3);
    endtask

    task automatic start(input logic [15:0] p);
        run = 1'b0;
        per = p;
        cyc(2);
        ticks_n = 0;
        last_m = 1;
        irqs = 0;
        wraps = 0;
        togs = 0;
        pin_p = pin;
        run = 1'b1;
    endtask

    task automatic wr(input logic [15:0] p);
        per = p;
        pw = 1'b1;
        cyc(1);
        pw = 1'b0;
        cyc(2);
    endtask

    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge clock);
        mismatches++;
        give_verdict();
    end

    initial begin
        cyc(4);
        rst = 1'b0;
        cyc(2);
        chk(rb, 16'hffff);
        chk({pin, irq, wirq, wflag}, 4'h0);
        mode = 3'h1;
        run = 1'b1;
        ticks(4);
        chk(rb, 16'hffff);
        chk(irqs, 0);
        chk(wraps, 0);
        mode = 3'h0;
        // Second compare set inside the interval must not disturb it
        start(16'h0002);
        cmp2 = 16'h0001;
        ticks(1);
        chk(rb, 16'h0000);
        chk(pin, 1'b1);
        chk(shd, 16'h0002);
        ticks(9);
        chk(irqs, 3);
        chk(ivl, 3);
        chk(togs, 4);
        chk(wflag, 1'b0);
        lvl = 1'b1;
        cyc(2);
        chk(pin, 1'b1);
        lvl = 1'b0;
        start(16'h0000);
        ticks(6);
        chk(irqs, 5);
        chk(ivl, 1);
        chk(rb, 16'h0000);
        // Event pin edges spaced well past the synchroniser latency
        ecs = 1'b1;
        start(16'h0001);
        repeat (7) begin
            epin = 1'b1;
            cyc(4);
            epin = 1'b0;
            cyc(4);
        end
        chk(irqs, 3);
        ecs = 1'b0;
        run = 1'b0;
        cyc(2);
        chk(rb, 16'hffff);
        // Lowering the period below the count forces a full wrap
        start(16'h0020);
        ticks(32'h22);
        chk(ivl, 32'h21);
        ticks(32'h18);
        chk(rb, 16'h0018);
        wr(16'h0010);
        chk(shd, 16'h0010);
        ticks(32'h10011 - 32'h19);
        chk(irqs, 1);
        chk(wflag, 1'b1);
        chk(wraps, 1);
        ticks(1);
        chk(irqs, 2);
        chk(ivl, 32'h10011);
        // Stop, then lower the period: no wrap, normal spacing
        start(16'h0003);
        ticks(1);
        chk(wflag, 1'b0);
        oe = 1'b0;
        cyc(2);
        chk(pin, 1'b0);
        oe = 1'b1;
        ticks(4);
        chk(irqs, 1);
        chk(ivl, 4);
        chk(wraps, 0);
        give_verdict();
    end
endmodule
`default_nettype wire
